/* verilog/acr_top.v */
`timescale 1ns/1ns
`include "acr_map.vh"

module acr_top (
    input wire clk_sys,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire cmp_in,
    output reg analog_power_on,
    output wire sample_hold_en,
    output wire [9:0] dac_code,
    output reg [2:0] channel_sel,
    output reg conv_irq
);

// ==========================================
// declarations
reg cmp_meta_q;
reg cmp_sync_q;
reg [7:0] ctrl_q;
reg [7:0] ctrl_d;
reg irq_en_q;
reg irq_en_d;
reg [2:0] chan_q;
reg [2:0] chan_d;
reg flag_q;
reg flag_d;
reg [9:0] res_q;
reg wr_pend_q;
reg [7:0] wr_addr_q;
reg [7:0] rd_hi;
reg [7:0] rd_lo;
reg [31:0] rd_word;
wire take_w;
wire [7:0] aoff_w;
wire ctrl_wr_w;
wire stat_wr_w;
wire res_rd_w;
wire pu_w;
wire start_w;
wire abort_w;
wire tick_w;
wire sample_w;
wire busy_w;
wire done_w;
wire [9:0] sar_w;
wire [9:0] result_w;
wire [9:0] dac_w;
wire [7:0] stat_rst_w;
wire rd_take_w;
wire wr_take_w;
wire hit_ctrl_w;
wire hit_stat_w;
wire hit_res_w;
wire [31:0] ctrl_word_w;
wire [31:0] stat_word_w;
wire [31:0] resh_word_w;
wire [31:0] resl_word_w;
wire [31:0] state_word_w;

// ==========================================
// comparator input synchroniser
always @(posedge clk_sys) begin
    if (!resetn) begin
        cmp_meta_q <= 1'b0;
        cmp_sync_q <= 1'b0;
    end else begin
        // only the second flop is read; the first may be metastable
        cmp_meta_q <= cmp_in;
        cmp_sync_q <= cmp_meta_q;
    end
end

// ==========================================
// bus address phase decode
assign take_w = hsel && hready && htrans[1];
assign aoff_w = haddr[7:0];

// one strobe per direction of a taken transfer
assign rd_take_w = take_w && !hwrite;
assign wr_take_w = take_w && hwrite;

// latched address compared once for both write strobes
assign hit_ctrl_w = (wr_addr_q == `ACR_ADDR_CTRL);
assign hit_stat_w = (wr_addr_q == `ACR_ADDR_STAT);

// writes act in the data phase, once hwdata is valid
assign ctrl_wr_w = wr_pend_q && hit_ctrl_w;
assign stat_wr_w = wr_pend_q && hit_stat_w;

// reads act in the address phase, read data is registered then
assign hit_res_w = (aoff_w == `ACR_ADDR_RESH) || (aoff_w == `ACR_ADDR_RESL);
assign res_rd_w = rd_take_w && hit_res_w;

always @(posedge clk_sys) begin
    if (!resetn) begin
        wr_pend_q <= 1'b0;
        wr_addr_q <= 8'h00;
    end else begin
        wr_pend_q <= wr_take_w;
        wr_addr_q <= take_w ? aoff_w : wr_addr_q;
    end
end

// ==========================================
// conversion control
assign pu_w = ctrl_q[`ACR_CTRL_PU];

assign start_w = stat_wr_w && pu_w;

assign abort_w = ctrl_wr_w || !pu_w;

acr_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(pu_w),
    .restart(start_w),
    .prs(ctrl_q[3:0]),
    .tick_q(tick_w)
);

acr_sar u_sar (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(tick_w),
    .start(start_w),
    .abort(abort_w),
    .cmp_hi(cmp_sync_q),
    .sample_q(sample_w),
    .busy_q(busy_w),
    .done_q(done_w),
    .dac_q(dac_w),
    .sar_q(sar_w),
    .result_q(result_w)
);

assign sample_hold_en = sample_w;
assign dac_code = dac_w;

// ==========================================
// register next values
always @* begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    chan_d = chan_q;
    // power-up only stores the bit, nothing else reloads
    if (ctrl_wr_w) begin
        ctrl_d = hwdata[7:0];
    end
    if (stat_wr_w) begin
        irq_en_d = hwdata[`ACR_STAT_IE];
        chan_d = hwdata[2:0];
    end
end

// ==========================================
// done flag next value
always @* begin
    flag_d = flag_q;
    if (stat_wr_w) begin
        flag_d = 1'b0;
    end
    if (res_rd_w) begin
        flag_d = 1'b0;
    end
    // flag sets with result load; set beats clear
    // a clear landing with the load would lose a result unseen
    if (done_w) begin
        flag_d = 1'b1;
    end
end

// ==========================================
// registers
// status reset word split into its fields
assign stat_rst_w = `ACR_STAT_RST;

always @(posedge clk_sys) begin
    if (!resetn) begin
        ctrl_q <= `ACR_CTRL_RST;
        irq_en_q <= stat_rst_w[`ACR_STAT_IE];
        chan_q <= stat_rst_w[2:0];
        flag_q <= 1'b0;
        res_q <= `ACR_RESULT_RST;
        analog_power_on <= 1'b0;
        channel_sel <= stat_rst_w[2:0];
    end else begin
        ctrl_q <= ctrl_d;
        irq_en_q <= irq_en_d;
        chan_q <= chan_d;
        flag_q <= flag_d;
        if (done_w) begin
            res_q <= result_w;
        end
        analog_power_on <= ctrl_d[`ACR_CTRL_PU];
        channel_sel <= chan_d;
    end
end

// ==========================================
// completion interrupt
always @(posedge clk_sys) begin
    if (!resetn) begin
        conv_irq <= 1'b0;
    end else begin
        // results loaded with flag, so ready when irq rises
        conv_irq <= flag_d && irq_en_d;
    end
end

// ==========================================
// result formatting
always @* begin
    rd_hi = 8'h00;
    rd_lo = 8'h00;
    if (ctrl_q[`ACR_CTRL_RES8] || !ctrl_q[`ACR_CTRL_DJM]) begin
        // left justified; sign only without right justification
        rd_hi = res_q[9:2];
        if (ctrl_q[`ACR_CTRL_SGN] && !ctrl_q[`ACR_CTRL_DJM]) begin
            rd_hi[7] = ~res_q[9];
        end
        if (!ctrl_q[`ACR_CTRL_RES8]) begin
            rd_lo = {res_q[1:0], 6'h00};
        end
    end else begin
        rd_hi = {6'h00, res_q[9:8]};
        rd_lo = res_q[7:0];
    end
end

// ==========================================
// register read words
assign ctrl_word_w = {24'h00_0000, ctrl_q};
assign stat_word_w = {24'h00_0000, flag_q, irq_en_q, 3'h0, chan_q};
assign resh_word_w = {24'h00_0000, rd_hi};
assign resl_word_w = {24'h00_0000, rd_lo};
// diagnostic view, lets software watch a conversion step by step
assign state_word_w = {18'h0_0000, tick_w, 1'b0, busy_w, sample_w, sar_w};

// ==========================================
// read mux
always @* begin
    rd_word = 32'h0000_0000;
    case (aoff_w)
        `ACR_ADDR_CTRL: begin
            rd_word = ctrl_word_w;
        end
        `ACR_ADDR_STAT: begin
            rd_word = stat_word_w;
        end
        `ACR_ADDR_RESH: begin
            rd_word = resh_word_w;
        end
        `ACR_ADDR_RESL: begin
            rd_word = resl_word_w;
        end
        `ACR_ADDR_STATE: begin
            rd_word = state_word_w;
        end
        default: begin
            // unmapped words read as zero
            rd_word = 32'h0000_0000;
        end
    endcase
end

// ==========================================
// bus response, zero wait states
always @(posedge clk_sys) begin
    if (!resetn) begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        hreadyout <= 1'b1;
        // okay only: no register refuses an access
        hresp <= 1'b0;
        if (rd_take_w) begin
            hrdata <= rd_word;
        end
    end
end

endmodule // acr_top

/* pkg/acr_map.vh */
`ifndef ACR_MAP_VH
`define ACR_MAP_VH

// ==========================================
// register byte addresses
`define ACR_ADDR_CTRL 8'h00
`define ACR_ADDR_STAT 8'h04
`define ACR_ADDR_RESH 8'h08
`define ACR_ADDR_RESL 8'h0C
`define ACR_ADDR_STATE 8'h10

// ==========================================
// field positions
`define ACR_CTRL_PU 7
`define ACR_CTRL_DJM 6
`define ACR_CTRL_RES8 5
`define ACR_CTRL_SGN 4
`define ACR_STAT_FLAG 7
`define ACR_STAT_IE 6

// ==========================================
// reset values
`define ACR_CTRL_RST 8'h00
`define ACR_STAT_RST 8'h00
`define ACR_RESULT_RST 10'h000

// ==========================================
// timing counts, in conversion clock cycles
`define ACR_SAMPLE_TICKS 4'hE

`endif

/* verilog/acr_prescaler.v */
`timescale 1ns/1ns
`include "acr_map.vh"

// conversion clock as a one-cycle tick every (prs+1)*2 bus cycles
module acr_prescaler (
    input wire clk_sys,
    input wire resetn,
    input wire run,
    input wire restart,
    input wire [3:0] prs,
    output reg tick_q
);

reg [4:0] cnt_q;
wire [4:0] last_w;

assign last_w = {prs, 1'b1};

// ==========================================
// divider
always @(posedge clk_sys) begin
    if (!resetn) begin
        cnt_q <= 5'h00;
        tick_q <= 1'b0;
    end else if (!run || restart) begin
        // restart aligns the sample window to the start request
        cnt_q <= 5'h00;
        tick_q <= 1'b0;
    end else if (cnt_q == last_w) begin
        cnt_q <= 5'h00;
        tick_q <= 1'b1;
    end else begin
        cnt_q <= cnt_q + 5'h01;
        tick_q <= 1'b0;
    end
end

endmodule // acr_prescaler

/* verilog/acr_sar.v */
`timescale 1ns/1ns
`include "acr_map.vh"

// sample phase then ten trial/decide steps, two conversion ticks each
module acr_sar (
    input wire clk_sys,
    input wire resetn,
    input wire tick,
    input wire start,
    input wire abort,
    input wire cmp_hi,
    output reg sample_q,
    output reg busy_q,
    output reg done_q,
    output reg [9:0] dac_q,
    output reg [9:0] sar_q,
    output reg [9:0] result_q
);

localparam ST_IDLE = 4'b0001;
localparam ST_SAMPLE = 4'b0010;
localparam ST_TRIAL = 4'b0100;
localparam ST_DECIDE = 4'b1000;

reg [3:0] state_q;
reg [3:0] cnt_q;
reg [3:0] bit_q;
wire [9:0] kept_w;

// trial code kept when the input is at or above it
assign kept_w = cmp_hi ? dac_q : sar_q;

always @(posedge clk_sys) begin
    if (!resetn) begin
        state_q <= ST_IDLE;
        cnt_q <= 4'h0;
        bit_q <= 4'h9;
        sample_q <= 1'b0;
        busy_q <= 1'b0;
        done_q <= 1'b0;
        dac_q <= 10'h000;
        sar_q <= 10'h000;
        result_q <= `ACR_RESULT_RST;
    end else begin
        done_q <= 1'b0;
        if (abort || start) begin
            state_q <= start ? ST_SAMPLE : ST_IDLE;
            cnt_q <= 4'h0;
            bit_q <= 4'h9;
            sample_q <= start;
            busy_q <= start;
            dac_q <= 10'h000;
            sar_q <= 10'h000;
        end else if (tick) begin
            case (state_q)
                ST_SAMPLE: begin
                    if (cnt_q == `ACR_SAMPLE_TICKS - 4'h1) begin
                        sample_q <= 1'b0;
                        state_q <= ST_TRIAL;
                    end
                    cnt_q <= cnt_q + 4'h1;
                end
                ST_TRIAL: begin
                    dac_q <= sar_q | (10'h001 << bit_q);
                    state_q <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    sar_q <= kept_w;
                    if (bit_q == 4'h0) begin
                        result_q <= kept_w;
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        bit_q <= bit_q - 4'h1;
                        state_q <= ST_TRIAL;
                    end
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule // acr_sar

/* tb/acr_comparator_model.sv */
`timescale 1ns/1ns
// ==========================================
// analog input and comparator
module acr_comparator_model (
    input wire clk_sys,
    input wire analog_power_on,
    input wire [9:0] dac_code,
    input wire [9:0] level,
    output reg cmp_in
);
    initial cmp_in = 1'b0;
    // unpowered output is meaningless, so it wobbles
    always @(posedge clk_sys) begin
        if (analog_power_on) begin
            cmp_in <= (level >= dac_code);
        end else begin
            cmp_in <= ~cmp_in;
        end
    end
endmodule // acr_comparator_model

/* tb/acr_properties.sv */
`timescale 1ns/1ns
// ==========================================
// port checks
module acr_properties (
    input wire clk_sys,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire analog_power_on,
    input wire sample_hold_en,
    input wire [9:0] dac_code,
    input wire [2:0] channel_sel,
    input wire conv_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire taken = hsel && hready && htrans[1];
    wire ctl_wr = taken && hwrite && haddr[7:0] == 8'h00;
    wire st_wr = taken && hwrite && haddr[7:0] == 8'h04;
    wire res_rd = taken && !hwrite && (haddr[7:0] == 8'h08 || haddr[7:0] == 8'h0C);
    reg ctl_dp_q;
    reg pw_q;
    reg [3:0] prs_q;
    reg [15:0] len_q;
    reg [2:0] clr_q;
    always @(posedge clk_sys) begin
        if (!resetn) begin
            ctl_dp_q <= 1'b0;
            pw_q <= 1'b0;
            prs_q <= 4'h0;
            len_q <= 16'h0000;
            clr_q <= 3'h0;
        end else begin
            ctl_dp_q <= ctl_wr;
            if (ctl_dp_q) begin
                pw_q <= hwdata[7];
                prs_q <= hwdata[3:0];
            end
            len_q <= sample_hold_en ? len_q + 16'h0001 : 16'h0000;
            clr_q <= {clr_q[1:0], st_wr | res_rd};
        end
    end
    sequence s_ctl_wr;
        ctl_wr;
    endsequence
    sequence s_st_wr;
        st_wr;
    endsequence
    sequence s_res_rd;
        res_rd;
    endsequence
    a_reset_clean: assert property ($rose(resetn) |-> !conv_irq && !analog_power_on && !sample_hold_en
        && dac_code == 10'h000 && channel_sel == 3'h0) else $error("outputs not clean after reset");
    a_status_clears: assert property (s_st_wr |-> ##3 !conv_irq) else $error("status write left irq");
    a_read_clears: assert property (s_res_rd |-> ##2 !conv_irq) else $error("result read left irq");
    a_ctrl_stops: assert property (s_ctl_wr ##1 !st_wr |-> ##1 (!sample_hold_en) [*2])
        else $error("ctrl write left sampling");
    a_start_cause: assert property ($rose(sample_hold_en) |-> $past(st_wr, 2))
        else $error("sampling began without status write");
    a_power_follows: assert property (s_ctl_wr ##1 1 |-> ##2 analog_power_on == pw_q)
        else $error("power output wrong");
    a_off_quiet: assert property (!analog_power_on [*2] |-> !sample_hold_en) else $error("sampling unpowered");
    // one extra bus cycle: the tick leaves the divider registered
    a_sample_window: assert property ($fell(sample_hold_en) |->
        len_q == 16'h001C * ({12'h000, prs_q} + 16'h0001) + 16'h0001) else $error("sample window length wrong");
    a_irq_holds: assert property ($fell(conv_irq) |-> |clr_q) else $error("irq dropped by itself");
    a_status_starts: assert property (s_st_wr ##0 analog_power_on |-> ##[4:40] sample_hold_en)
        else $error("status write did not start");
endmodule // acr_properties

bind acr_top acr_properties u_props (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .analog_power_on(analog_power_on),
    .sample_hold_en(sample_hold_en), .dac_code(dac_code), .channel_sel(channel_sel), .conv_irq(conv_irq));

/* tb/adc_reset_and_completion_irq_tb.sv */
`timescale 1ns/1ns
module adc_reset_and_completion_irq_tb;
    reg clk_sys = 1'b0;
    reg resetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    reg [9:0] level = 10'h2B6;
    wire hready, hresp, cmp_in, analog_power_on, sample_hold_en, conv_irq;
    wire [31:0] hrdata;
    wire [9:0] dac_code;
    wire [2:0] channel_sel;
    integer miscompares = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i, n;
    reg [31:0] rd;
    always #4 clk_sys = ~clk_sys;
    acr_top dut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .cmp_in(cmp_in), .analog_power_on(analog_power_on),
        .sample_hold_en(sample_hold_en), .dac_code(dac_code), .channel_sel(channel_sel), .conv_irq(conv_irq));
    acr_comparator_model u_cmp (.clk_sys(clk_sys), .analog_power_on(analog_power_on), .dac_code(dac_code),
        .level(level), .cmp_in(cmp_in));
    // ==========================================
    // helpers
    task report_and_stop;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
    end
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task ahb(input [7:0] a, input w, input [7:0] d);
        begin
            @(posedge clk_sys);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {24'h0, a};
            do @(posedge clk_sys); while (hready !== 1'b1);
            htrans <= 2'h0;
            hwdata <= {24'h0, d};
            do @(posedge clk_sys); while (hready !== 1'b1);
            rd = hrdata;
        end
    endtask
    task idle(input integer k);
        repeat (k) @(posedge clk_sys);
    endtask
    task wait_irq;
        for (n = 0; conv_irq !== 1'b1 && n < 600; n = n + 1) @(posedge clk_sys);
    endtask
    task pulse_reset;
        begin
            @(posedge clk_sys);
            resetn <= 1'b0;
            idle(3);
            resetn <= 1'b1;
            idle(1);
        end
    endtask
    // ==========================================
    // scenarios
    task t_after_reset;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                ahb(8'(i * 4), 1'b0, 8'h00);
                chk("reg", 32'h0, rd);
            end
            chk("power", 32'h0, {31'h0, analog_power_on});
            chk("hresp", 32'h0, {31'h0, hresp});
        end
    endtask
    task t_irq_convert;
        begin
            ahb(8'h00, 1'b1, 8'h83);
            ahb(8'h04, 1'b1, 8'h45);
            wait_irq;
            chk("irq_delay", 32'h1, {31'h0, n >= 270 && n <= 280});
            idle(20);
            chk("irq_held", 32'h1, {31'h0, conv_irq});
            ahb(8'h04, 1'b0, 8'h00);
            chk("stat_done", 32'hC5, rd);
            ahb(8'h08, 1'b0, 8'h00);
            chk("res_hi", {24'h0, level[9:2]}, rd);
            ahb(8'h0C, 1'b0, 8'h00);
            chk("res_lo", {24'h0, level[1:0], 6'h00}, rd);
            ahb(8'h00, 1'b1, 8'hC3);
            ahb(8'h08, 1'b0, 8'h00);
            chk("res_hi_right", {30'h0, level[9:8]}, rd);
            ahb(8'h0C, 1'b0, 8'h00);
            chk("res_lo_right", {24'h0, level[7:0]}, rd);
            ahb(8'h00, 1'b1, 8'hB3);
            ahb(8'h08, 1'b0, 8'h00);
            chk("res_hi_signed", {24'h0, ~level[9], level[8:2]}, rd);
            ahb(8'h0C, 1'b0, 8'h00);
            chk("res_lo_8bit", 32'h0, rd);
            ahb(8'h00, 1'b1, 8'h83);
            ahb(8'h04, 1'b0, 8'h00);
            chk("stat_read", 32'h45, rd);
            chk("irq_read", 32'h0, {31'h0, conv_irq});
        end
    endtask
    task t_poll_clear;
        begin
            ahb(8'h04, 1'b1, 8'h02);
            // interrupt off, so software polls the flag
            for (i = 0; i < 200 && rd[7] !== 1'b1; i = i + 1) ahb(8'h04, 1'b0, 8'h00);
            chk("poll", 32'h82, rd);
            chk("irq_off", 32'h0, {31'h0, conv_irq});
            ahb(8'h04, 1'b1, 8'h02);
            ahb(8'h04, 1'b0, 8'h00);
            chk("stat_wr_clr", 32'h02, rd);
            idle(150);
            ahb(8'h00, 1'b1, 8'h83);
            idle(400);
            ahb(8'h04, 1'b0, 8'h00);
            chk("aborted", 32'h02, rd);
            ahb(8'h00, 1'b0, 8'h00);
            chk("ctrl_kept", 32'h83, rd);
        end
    endtask
    task t_restart;
        begin
            ahb(8'h04, 1'b1, 8'h40);
            idle(150);
            ahb(8'h04, 1'b1, 8'h40);
            wait_irq;
            chk("restart", 32'h1, {31'h0, n >= 270 && n <= 280});
            pulse_reset;
            chk("irq_rst", 32'h0, {31'h0, conv_irq});
            t_after_reset;
        end
    endtask
    task t_power_keep;
        begin
            ahb(8'h04, 1'b1, 8'h46);
            ahb(8'h00, 1'b1, 8'h83);
            ahb(8'h04, 1'b0, 8'h00);
            chk("stat_kept", 32'h46, rd);
            chk("channel", 32'h6, {29'h0, channel_sel});
            ahb(8'h04, 1'b1, 8'h46);
            idle(150);
            ahb(8'h00, 1'b1, 8'h03);
            idle(400);
            chk("power_off", 32'h0, {31'h0, analog_power_on | conv_irq});
            ahb(8'h00, 1'b1, 8'h83);
            ahb(8'h04, 1'b1, 8'h46);
            idle(150);
            pulse_reset;
            ahb(8'h10, 1'b0, 8'h00);
            chk("state_rst", 32'h0, rd);
            idle(400);
            ahb(8'h04, 1'b0, 8'h00);
            chk("no_done", 32'h0, rd);
        end
    endtask
    initial begin
        idle(12);
        resetn <= 1'b1;
        t_after_reset;
        t_irq_convert;
        t_poll_clear;
        t_restart;
        t_power_keep;
        report_and_stop;
    end
endmodule // adc_reset_and_completion_irq_tb
